/* lres_cfg.svh */
// Event numbers, unit-mask values and field positions for the L2 request event selector.
`ifndef LRES_CFG_SVH
`define LRES_CFG_SVH

`define LRES_EV_ALL_REQ 8'h24
`define LRES_EV_DATA_REQ 8'h26
`define LRES_EV_WRITE_REQ 8'h27

`define LRES_MASK_ALL 8'hFF
`define LRES_MASK_DEMAND_ANY 8'h0F
`define LRES_MASK_PREF_ANY 8'hF0
`define LRES_MASK_RFO_HIT 8'h0E
`define LRES_MASK_LOCK_HIT 8'hE0

`define LRES_LO_LSB 0
`define LRES_HI_LSB 4
`define LRES_NIB_W 4

`define LRES_ONEHOT_I 4'h1
`define LRES_ONEHOT_S 4'h2
`define LRES_ONEHOT_E 4'h4
`define LRES_ONEHOT_M 4'h8
`define LRES_ONEHOT_NONE 4'h0

`endif

/* lres_event_selector.sv */
// Performance event qualifier for second-level cache requests.
//
// Operation
// - Event 24H with mask FFH counts every L2 request, code and data.
// - Event 26H low mask bits count demand loads by state I, S, E, M.
// - Demand loads include L1D demand misses and L1D prefetches.
// - Event 26H mask 0FH counts every demand data request in any state.
// - Event 26H high mask bits count prefetch loads by state I, S, E, M.
// - Prefetch ownership read to a shared line misses; plain prefetch read hits.
// - Event 26H mask F0H counts every prefetch data request in any state.
// - Event 26H mask FFH counts all demand and prefetch data requests.
// - Event 27H low mask bits count store ownership reads by line state.
// - Every counted store ownership read is a demand request.
// - Event 27H mask 0EH counts store ownership reads that hit.
// - Event 27H mask 0FH counts every store ownership read.
// - Event 27H high mask bits count locked ownership reads by line state.
// - Event 27H mask E0H counts locked ownership reads that hit.
// - Event 27H mask F0H counts every locked ownership read.
`timescale 1ns/100ps
`include "lres_cfg.svh"

module lres_event_selector (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire lres_pkg::lres_sel_type sel,
  input wire lres_pkg::lres_req_type req,
  output logic count_inc,
  output logic count_hit,
  output logic event_known
);

  // Maps a line state to one mask bit, folding a shared-line prefetch ownership read to a miss.
  function automatic logic [3:0] state_onehot(
    input lres_pkg::lres_line_state_type line_state,
    input logic own_prefetch
  );
    logic [3:0] bits;
    bits = `LRES_ONEHOT_NONE;
    case (line_state)
      lres_pkg::line_invalid: bits = `LRES_ONEHOT_I;
      lres_pkg::line_shared: bits = own_prefetch ? `LRES_ONEHOT_I : `LRES_ONEHOT_S;
      lres_pkg::line_exclusive: bits = `LRES_ONEHOT_E;
      lres_pkg::line_modified: bits = `LRES_ONEHOT_M;
      default: bits = `LRES_ONEHOT_NONE;
    endcase
    return bits;
  endfunction : state_onehot

  // A nibble of the unit mask matches when any set bit selects the request's state.
  function automatic logic nibble_hit(
    input logic [3:0] nibble,
    input logic [3:0] onehot
  );
    return |(nibble & onehot);
  endfunction : nibble_hit

  lres_pkg::lres_state_type st;
  lres_pkg::lres_state_type next_st;
  logic [3:0] onehot;
  logic [3:0] lo_mask;
  logic [3:0] hi_mask;
  logic is_demand_load;
  logic is_prefetch_load;
  logic known;
  logic match;

  assign lo_mask = sel.unit_mask[`LRES_LO_LSB +: `LRES_NIB_W];
  assign hi_mask = sel.unit_mask[`LRES_HI_LSB +: `LRES_NIB_W];
  assign onehot = state_onehot(req.line_state, req.req_class == lres_pkg::req_l2_prefetch_rfo);

  // L1D prefetches arrive at L2 as demand loads, so they share the demand mask bits.
  assign is_demand_load = (req.req_class == lres_pkg::req_l1d_demand) ||
                          (req.req_class == lres_pkg::req_l1d_prefetch);
  assign is_prefetch_load = (req.req_class == lres_pkg::req_l2_prefetch_read) ||
                            (req.req_class == lres_pkg::req_l2_prefetch_rfo);

  always_comb
  begin
    known = 1'b0;
    match = 1'b0;
    case (sel.event_num)
      `LRES_EV_ALL_REQ:
      begin
        // Only the aggregate mask is decoded for this event; partial masks count nothing.
        known = (sel.unit_mask == `LRES_MASK_ALL);
        match = known;
      end
      `LRES_EV_DATA_REQ:
      begin
        known = 1'b1;
        match = (is_demand_load && nibble_hit(lo_mask, onehot)) ||
                (is_prefetch_load && nibble_hit(hi_mask, onehot));
      end
      `LRES_EV_WRITE_REQ:
      begin
        known = 1'b1;
        // Ownership-read prefetches never reach this class, so all of these are demand.
        match = ((req.req_class == lres_pkg::req_store_rfo) &&
                 nibble_hit(lo_mask, onehot)) ||
                ((req.req_class == lres_pkg::req_lock_rfo) &&
                 nibble_hit(hi_mask, onehot));
      end
      default:
      begin
        known = 1'b0;
        match = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    next_st = st;
    if (clk_en)
    begin
      next_st.event_known = known;
      next_st.count_inc = req.valid && match;
      next_st.count_hit = req.valid && match && (onehot != `LRES_ONEHOT_I);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign count_inc = st.count_inc;
  assign count_hit = st.count_hit;
  assign event_known = st.event_known;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic live;
  assign live = clk_en && req.valid;

  chk_all_requests: assert property (
    live && sel.event_num == `LRES_EV_ALL_REQ && sel.unit_mask == `LRES_MASK_ALL
    |=> count_inc && event_known)
    else $error("aggregate request event did not count");

  chk_demand_by_state: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && req.req_class == lres_pkg::req_l1d_demand &&
    req.line_state == lres_pkg::line_exclusive && sel.unit_mask == 8'h04
    |=> count_inc && count_hit)
    else $error("demand load on exclusive line not counted");

  chk_l1d_prefetch_demand: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && req.req_class == lres_pkg::req_l1d_prefetch
    && sel.unit_mask == `LRES_MASK_DEMAND_ANY
    |=> count_inc)
    else $error("L1D prefetch not counted as demand load");

  chk_demand_any: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && sel.unit_mask == `LRES_MASK_DEMAND_ANY
    |=> count_inc == $past(is_demand_load))
    else $error("demand any-state count wrong");

  chk_prefetch_by_state: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ &&
    req.req_class == lres_pkg::req_l2_prefetch_read &&
    req.line_state == lres_pkg::line_modified && sel.unit_mask == 8'h80
    |=> count_inc && count_hit)
    else $error("prefetch load on modified line not counted");

  chk_prefetch_rfo_shared: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && req.line_state == lres_pkg::line_shared &&
    sel.unit_mask == 8'h20
    |=> count_inc == ($past(req.req_class) == lres_pkg::req_l2_prefetch_read))
    else $error("shared-line prefetch hit or miss wrong");

  chk_prefetch_any: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && sel.unit_mask == `LRES_MASK_PREF_ANY
    |=> count_inc == $past(is_prefetch_load))
    else $error("prefetch any-state count wrong");

  chk_data_any: assert property (
    live && sel.event_num == `LRES_EV_DATA_REQ && sel.unit_mask == `LRES_MASK_ALL
    |=> count_inc == ($past(is_demand_load) || $past(is_prefetch_load)))
    else $error("all data request count wrong");

  chk_store_rfo_hit: assert property (
    live && sel.event_num == `LRES_EV_WRITE_REQ && sel.unit_mask == `LRES_MASK_RFO_HIT
    && req.req_class == lres_pkg::req_store_rfo
    |=> count_inc == ($past(req.line_state) != lres_pkg::line_invalid))
    else $error("store ownership read hit count wrong");

  chk_store_rfo_any: assert property (
    live && sel.event_num == `LRES_EV_WRITE_REQ && sel.unit_mask == `LRES_MASK_DEMAND_ANY
    |=> count_inc == ($past(req.req_class) == lres_pkg::req_store_rfo))
    else $error("store ownership read any count wrong");

  chk_lock_rfo_hit: assert property (
    live && sel.event_num == `LRES_EV_WRITE_REQ && sel.unit_mask == `LRES_MASK_LOCK_HIT
    |=> count_inc == ($past(req.req_class) == lres_pkg::req_lock_rfo &&
                      $past(req.line_state) != lres_pkg::line_invalid))
    else $error("locked ownership read hit count wrong");

  chk_lock_rfo_any: assert property (
    live && sel.event_num == `LRES_EV_WRITE_REQ && sel.unit_mask == `LRES_MASK_PREF_ANY
    |=> count_inc == ($past(req.req_class) == lres_pkg::req_lock_rfo))
    else $error("locked ownership read any count wrong");

  chk_no_count_unknown: assert property (
    clk_en && sel.event_num != `LRES_EV_ALL_REQ && sel.event_num != `LRES_EV_DATA_REQ &&
    sel.event_num != `LRES_EV_WRITE_REQ
    |=> !count_inc && !event_known)
    else $error("undecoded event produced an increment");

  chk_idle_no_count: assert property (
    clk_en && !req.valid |=> !count_inc && !count_hit)
    else $error("increment without a request");

  chk_freeze_hold: assert property (
    !clk_en |=> $stable(count_inc) && $stable(count_hit) && $stable(event_known))
    else $error("state moved while clock enable was low");

  cov_demand_miss: cover property (
    live && sel.event_num == `LRES_EV_DATA_REQ && is_demand_load &&
    req.line_state == lres_pkg::line_invalid ##1 count_inc);

  cov_prefetch_rfo_shared: cover property (
    live && req.req_class == lres_pkg::req_l2_prefetch_rfo &&
    req.line_state == lres_pkg::line_shared ##1 count_inc && !count_hit);

  cov_lock_hit: cover property (
    live && sel.event_num == `LRES_EV_WRITE_REQ && req.req_class == lres_pkg::req_lock_rfo
    ##1 count_hit);

  cov_back_to_back: cover property (count_inc [*3]);

endmodule : lres_event_selector

/* lres_pipe_model.sv */
// Behavioural model of the cache request pipeline that feeds the event selector.
`timescale 1ns/100ps

module lres_pipe_model (
  input wire logic sys_clk,
  input wire logic fire,
  input wire lres_pkg::lres_req_class_type cls,
  input wire lres_pkg::lres_line_state_type st,
  output lres_pkg::lres_req_type req
);
  initial req = '0;
  // Store ownership reads are only ever issued as demand traffic.
  // First-level prefetches travel beside demand misses as their own class.
  // Idle cycles invert the last class and state so stale fields never look valid.
  always @(negedge sys_clk)
  begin
    if (fire)
      req <= '{valid: 1'b1, req_class: cls, line_state: st};
    else
      req <= '{valid: 1'b0, req_class: lres_pkg::lres_req_class_type'(~req.req_class),
               line_state: lres_pkg::lres_line_state_type'(~req.line_state)};
  end
endmodule : lres_pipe_model

/* lres_pkg.sv */
// Types shared by the L2 request event selector and its environment.
package lres_pkg;

  typedef enum logic [2:0] {
    req_code_fetch,
    req_l1d_demand,
    req_l1d_prefetch,
    req_l2_prefetch_read,
    req_l2_prefetch_rfo,
    req_store_rfo,
    req_lock_rfo,
    req_other
  } lres_req_class_type;

  typedef enum logic [1:0] {
    line_invalid,
    line_shared,
    line_exclusive,
    line_modified
  } lres_line_state_type;

  typedef struct packed {
    logic valid;
    lres_req_class_type req_class;
    lres_line_state_type line_state;
  } lres_req_type;

  typedef struct packed {
    logic [7:0] event_num;
    logic [7:0] unit_mask;
  } lres_sel_type;

  typedef struct packed {
    logic count_inc;
    logic count_hit;
    logic event_known;
  } lres_state_type;

endpackage : lres_pkg

/* test_lres_event_selector.sv */
// Self-checking testbench for the second-level cache request event selector.
`timescale 1ns/100ps

module test_lres_event_selector;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic fire;
  lres_pkg::lres_sel_type sel;
  lres_pkg::lres_req_class_type cls;
  lres_pkg::lres_line_state_type st;
  lres_pkg::lres_req_type req;
  logic count_inc;
  logic count_hit;
  logic event_known;
  logic [2:0] exp_out;
  int n_mismatch;
  int n_tests;
  int seed_init;
  logic [7:0] ev_tab [4] = '{8'h24, 8'h26, 8'h27, 8'h25};
  logic [7:0] mask_tab [15] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                               8'h0F, 8'hF0, 8'hFF, 8'h0E, 8'hE0, 8'hFE, 8'h00};

  lres_pipe_model partner (.sys_clk(sys_clk), .fire(fire), .cls(cls), .st(st), .req(req));

  lres_event_selector dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .sel(sel),
    .req(req), .count_inc(count_inc), .count_hit(count_hit), .event_known(event_known));

  // Returns increment, hit and decoded flags for one sampled request.
  function automatic logic [2:0] calc(lres_pkg::lres_sel_type s, lres_pkg::lres_req_type r);
    logic known;
    logic inc;
    int eff;
    int b;
    eff = int'(r.line_state);
    if (r.req_class == lres_pkg::req_l2_prefetch_rfo && r.line_state == lres_pkg::line_shared)
      eff = 0;
    b = -1;
    known = (s.event_num == 8'h24 && s.unit_mask == 8'hFF) || s.event_num == 8'h26 ||
            s.event_num == 8'h27;
    if (s.event_num == 8'h26)
    begin
      case (r.req_class)
        lres_pkg::req_l1d_demand, lres_pkg::req_l1d_prefetch: b = eff;
        lres_pkg::req_l2_prefetch_read, lres_pkg::req_l2_prefetch_rfo: b = 4 + eff;
        default: b = -1;
      endcase
    end
    if (s.event_num == 8'h27)
    begin
      case (r.req_class)
        lres_pkg::req_store_rfo: b = eff;
        lres_pkg::req_lock_rfo: b = 4 + eff;
        default: b = -1;
      endcase
    end
    inc = r.valid && known && (s.event_num == 8'h24 || (b >= 0 && s.unit_mask[b]));
    return {inc, inc && eff != 0, known};
  endfunction : calc

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      exp_out <= 3'h0;
    else if (clk_en)
      exp_out <= calc(sel, req);
  end

  task automatic check_bit(input logic got, input logic exp_v);
    n_tests++;
    if (got !== exp_v)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask : check_bit

  // Compares the outputs of the edge just passed, then presents the next cycle.
  task automatic step(input logic [7:0] ev, input logic [7:0] m, input int c, input int s,
                      input logic v, input logic en);
    @(negedge sys_clk);
    check_bit(count_inc, exp_out[2]);
    check_bit(count_hit, exp_out[1]);
    check_bit(event_known, exp_out[0]);
    sel <= '{event_num: ev, unit_mask: m};
    cls <= lres_pkg::lres_req_class_type'(c);
    st <= lres_pkg::lres_line_state_type'(s);
    fire <= v;
    clk_en <= en;
  endtask : step

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // The run needs under 5000 cycles; the limit leaves ample margin.
  initial
  begin
    #(50 * 8000);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b0;
    fire = 1'b0;
    sel = '0;
    cls = lres_pkg::req_code_fetch;
    st = lres_pkg::line_invalid;
    n_mismatch = 0;
    n_tests = 0;
    seed_init = $urandom(8719);
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    foreach (ev_tab[e])
      foreach (mask_tab[k])
        for (int c = 0; c < 8; c++)
          for (int s = 0; s < 4; s++)
            step(ev_tab[e], mask_tab[k], c, s, 1'b1, 1'b1);
    for (int i = 0; i < 3000; i++)
      step(ev_tab[$urandom_range(3)],
           ($urandom_range(1) == 1) ? mask_tab[$urandom_range(14)] : 8'($urandom()),
           $urandom_range(7), $urandom_range(3), 1'($urandom()), $urandom_range(3) != 0);
    step(8'h00, 8'h00, 0, 0, 1'b0, 1'b1);
    step(8'h00, 8'h00, 0, 0, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : test_lres_event_selector
